// >>> common/timer_set_pkg.sv
package timer_set_pkg;
    // Channel layout: 0 stand-alone, 1/2 first pair, 3/4 second pair
    localparam int CH_NUM = 5;
    localparam int TRIG_CH = 4;
    localparam int ADDR_W_MIN = 8;

    // Byte offsets within a channel block, channel block stride 16 bytes
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PERIOD = 4'h4;
    localparam logic [3:0] OFS_COUNT = 4'h8;
    localparam int CH_SHIFT = 4;
    localparam logic [7:0] STATUS_ADDR = 8'h50;
    localparam logic [7:0] MASK_ADDR = 8'h54;

    // Control field positions
    localparam int RUN_BIT = 15;
    localparam int IDLE_BIT = 13;
    localparam int GATE_BIT = 6;
    localparam int PRE_HI = 5;
    localparam int PRE_LO = 4;
    localparam int JOIN_BIT = 3;
    localparam int SYNC_BIT = 2;
    localparam int CSRC_BIT = 1;

    // Implemented control bits per channel kind
    localparam logic [15:0] CTRL_MASK_SA = 16'ha076;
    localparam logic [15:0] CTRL_MASK_LO = 16'ha07a;
    localparam logic [15:0] CTRL_MASK_UP = 16'ha072;

    // Prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
    localparam logic [7:0] PRE_LIM_1 = 8'h00;
    localparam logic [7:0] PRE_LIM_8 = 8'h07;
    localparam logic [7:0] PRE_LIM_64 = 8'h3f;
    localparam logic [7:0] PRE_LIM_256 = 8'hff;
    localparam logic [1:0] PRE_SEL_1 = 2'h0;
    localparam logic [1:0] PRE_SEL_8 = 2'h1;
    localparam logic [1:0] PRE_SEL_64 = 2'h2;
    localparam logic [1:0] PRE_SEL_256 = 2'h3;

    // Reset values
    localparam logic [15:0] CTRL_RST = 16'h0000;
    localparam logic [15:0] PERIOD_RST = 16'hffff;
    localparam logic [15:0] COUNT_RST = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/timer_set.sv
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
// Operation
// RULE1: Stand-alone timer: timer, synchronous or asynchronous counter.
// RULE2: Stand-alone interrupt on period match or gated gate falling edge.
// RULE3: Run enable bit 15 starts counting when 1, stops when 0.
// RULE4: Idle halt bit 13 stops the timer during idle, else it runs.
// RULE5: Gate bit makes internal-clock timer count only while gate high.
// RULE6: Prescale bits 5-4 divide by 1, 8, 64 or 256.
// RULE7: Stand-alone sync bit 2 syncs external clock; ignored on internal.
// RULE8: Clock source bit 1 picks external rising edges or instruction clock.
// RULE9: Join bit 3 of lower control makes one 32-bit timer, lower is LSW.
// RULE10: Joined, upper control ignored; lower control, clock, gate govern.
// RULE11: Joined, interrupt goes to the upper timer flag only.
// RULE12: Joined period is upper period high word, lower period low word.
// RULE13: Joined, upper count holds high word, lower count low word.
// RULE14: Unjoined pair timers run independently with no asynchronous mode.
// RULE15: Joined timer interrupts when 32-bit count matches 32-bit period.
// RULE16: Converter trigger comes only from the second pair's upper timer.
// RULE17: Unimplemented control bits ignore writes and read zero.
// RULE18: Count increments per tick; on period match wraps to zero and flags.
// RULE19: Joined, upper word increments when lower word rolls over.
module timer_set #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [timer_set_pkg::CH_NUM-1:0] ext_clock_pin,
    input wire logic [timer_set_pkg::CH_NUM-1:0] gate_pin,
    input wire logic idle_mode,
    output logic irq,
    output logic adc_trigger
);

    localparam int N = timer_set_pkg::CH_NUM;

    if (ADDR_W < timer_set_pkg::ADDR_W_MIN) begin : g_chk
        $error("timer_set: ADDR_W too small for the register map");
    end

    logic [ADDR_W-1:0] aw_addr_reg;
    logic aw_full_reg, w_full_reg, awready_reg, wready_reg, bvalid_reg;
    logic arready_reg, rvalid_reg, wr_en, wr_ok, rd_ok, instr_en_reg;
    logic irq_reg, trig_reg;
    logic [31:0] w_data_reg, rdata_reg, rd_word;
    logic [3:0] w_strb_reg, wr_ofs;
    logic [1:0] bresp_reg, rresp_reg;
    logic [2:0] wr_ch;
    logic [N-1:0] status_reg, mask_reg, tick_w, event_w;
    logic [15:0] ctrl_w [N], period_w [N], count_w [N];

    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
        logic [15:0] v;
        v = old;
        if (s[0]) v[7:0] = d[7:0];
        if (s[1]) v[15:8] = d[15:8];
        return v;
    endfunction

    function automatic logic mapped(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] hi;
        logic [2:0] ch;
        hi = a >> 7;
        ch = a[6:4];
        if (hi != '0) begin
            return 1'b0;
        end
        if (a[7:0] == timer_set_pkg::STATUS_ADDR ||
            a[7:0] == timer_set_pkg::MASK_ADDR) begin
            return 1'b1;
        end
        return (32'(ch) < 32'(N)) && (a[3:2] != 2'h3);
    endfunction

    // Instruction clock enable, half of the system clock
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            instr_en_reg <= 1'b0;
        end else begin
            instr_en_reg <= ~instr_en_reg; // RULE8
        end
    end

    // AXI write address and data capture, in either order
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_addr_reg <= '0;
            aw_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            w_full_reg <= 1'b0;
            wready_reg <= 1'b1;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                aw_addr_reg <= s_axi_awaddr;
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
            end else if (wr_en) begin
                aw_full_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready) begin
                awready_reg <= 1'b1;
            end
            if (s_axi_wvalid && wready_reg) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
            end else if (wr_en) begin
                w_full_reg <= 1'b0;
            end else if (bvalid_reg && s_axi_bready) begin
                wready_reg <= 1'b1;
            end
        end
    end

    assign wr_en = aw_full_reg & w_full_reg & ~bvalid_reg;
    assign wr_ok = mapped(aw_addr_reg);
    assign wr_ch = aw_addr_reg[6:4];
    assign wr_ofs = {aw_addr_reg[3:2], 2'b00};

    // Write response
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= timer_set_pkg::RESP_OKAY;
        end else if (wr_en) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wr_ok ? timer_set_pkg::RESP_OKAY
                               : timer_set_pkg::RESP_SLVERR;
        end else if (bvalid_reg && s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read mux
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_ok = mapped(s_axi_araddr);
        if (s_axi_araddr[7:0] == timer_set_pkg::STATUS_ADDR) begin
            rd_word = 32'(status_reg);
        end else if (s_axi_araddr[7:0] == timer_set_pkg::MASK_ADDR) begin
            rd_word = 32'(mask_reg);
        end else begin
            for (int k = 0; k < N; k++) begin
                if (32'(s_axi_araddr[6:4]) == k) begin
                    unique case ({s_axi_araddr[3:2], 2'b00})
                        timer_set_pkg::OFS_CTRL: begin
                            rd_word = {16'h0000, ctrl_w[k]}; // RULE17
                        end
                        timer_set_pkg::OFS_PERIOD: begin
                            rd_word = {16'h0000, period_w[k]};
                        end
                        timer_set_pkg::OFS_COUNT: begin
                            rd_word = {16'h0000, count_w[k]}; // RULE13
                        end
                        default: begin
                            rd_word = 32'h0000_0000;
                        end
                    endcase
                end
            end
        end
        if (!rd_ok) begin
            rd_word = 32'h0000_0000;
        end
    end

    // Read channel
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= timer_set_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_word;
            rresp_reg <= rd_ok ? timer_set_pkg::RESP_OKAY
                               : timer_set_pkg::RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Timer channels
    for (genvar i = 0; i < N; i++) begin : g_ch
        localparam bit IS_LOWER = (i % 2 == 1);
        localparam bit IS_UPPER = (i != 0) && (i % 2 == 0);
        localparam int LO = IS_UPPER ? i - 1 : i;
        localparam int HI = IS_LOWER ? i + 1 : i;
        localparam logic [15:0] WMASK = (i == 0) ?
            timer_set_pkg::CTRL_MASK_SA :
            (IS_LOWER ? timer_set_pkg::CTRL_MASK_LO
                      : timer_set_pkg::CTRL_MASK_UP);
        logic [15:0] ctrl_reg, period_reg, count_reg;
        logic [7:0] pre_reg, pre_lim;
        logic s1_reg, s2_reg, clk_prev_reg, gate_prev_reg, wr_hit;
        logic joined, clk_sel, base_tick, gate_ok, run, step;
        logic own_tick, tick, match, carry, gate_fall;

        assign ctrl_w[i] = ctrl_reg;
        assign period_w[i] = period_reg;
        assign count_w[i] = count_reg;
        assign wr_hit = wr_en && wr_ok && (32'(wr_ch) == i);
        assign joined = (i != 0) &&
                        ctrl_w[LO][timer_set_pkg::JOIN_BIT]; // RULE9

        // External clock synchroniser and edge detect
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                clk_prev_reg <= 1'b0;
                gate_prev_reg <= 1'b0;
            end else begin
                s1_reg <= ext_clock_pin[i];
                s2_reg <= s1_reg;
                clk_prev_reg <= clk_sel;
                gate_prev_reg <= gate_pin[i];
            end
        end

        // Only the stand-alone timer may bypass synchronisation
        assign clk_sel = (i == 0 && !ctrl_reg[timer_set_pkg::SYNC_BIT])
                         ? ext_clock_pin[i] : s2_reg; // RULE7 RULE14 RULE1
        assign base_tick = ctrl_reg[timer_set_pkg::CSRC_BIT]
                           ? (clk_sel & ~clk_prev_reg) : instr_en_reg; // RULE8
        assign gate_ok = ctrl_reg[timer_set_pkg::CSRC_BIT] |
                         ~ctrl_reg[timer_set_pkg::GATE_BIT] |
                         gate_pin[i]; // RULE5
        assign run = ctrl_reg[timer_set_pkg::RUN_BIT] & // RULE3
                     ~(ctrl_reg[timer_set_pkg::IDLE_BIT] & idle_mode); // RULE4
        assign step = run & gate_ok & base_tick;

        always_comb begin
            unique case (ctrl_reg[timer_set_pkg::PRE_HI:timer_set_pkg::PRE_LO])
                timer_set_pkg::PRE_SEL_1: pre_lim = timer_set_pkg::PRE_LIM_1;
                timer_set_pkg::PRE_SEL_8: pre_lim = timer_set_pkg::PRE_LIM_8;
                timer_set_pkg::PRE_SEL_64: pre_lim = timer_set_pkg::PRE_LIM_64;
                timer_set_pkg::PRE_SEL_256: begin
                    pre_lim = timer_set_pkg::PRE_LIM_256;
                end
            endcase
        end

        assign own_tick = step & (pre_reg >= pre_lim); // RULE6
        assign tick_w[i] = own_tick;
        // Joined upper half follows the lower half's clock, gate, control
        assign tick = (joined && IS_UPPER) ? tick_w[LO] : own_tick; // RULE10
        assign match = joined
            ? ({count_w[HI], count_w[LO]} ==
               {period_w[HI], period_w[LO]})
            : (count_reg == period_reg); // RULE12 RULE15
        assign carry = !joined || IS_LOWER ||
                       (count_w[LO] == timer_set_pkg::COUNT_MAX); // RULE19
        assign gate_fall = (i == 0) && run &&
                           !ctrl_reg[timer_set_pkg::CSRC_BIT] &&
                           ctrl_reg[timer_set_pkg::GATE_BIT] &&
                           gate_prev_reg && !gate_pin[i]; // RULE2
        assign event_w[i] = (tick & match & ~(joined & IS_LOWER)) |
                            gate_fall; // RULE11 RULE18 RULE2

        // Prescaler
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                pre_reg <= 8'h00;
            end else if (!run ||
                         (wr_hit && wr_ofs == timer_set_pkg::OFS_CTRL)) begin
                pre_reg <= 8'h00;
            end else if (step) begin
                pre_reg <= own_tick ? 8'h00 : pre_reg + 8'h01; // RULE6
            end
        end

        // Control and period registers
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                ctrl_reg <= timer_set_pkg::CTRL_RST;
                period_reg <= timer_set_pkg::PERIOD_RST;
            end else if (wr_hit) begin
                if (wr_ofs == timer_set_pkg::OFS_CTRL) begin
                    ctrl_reg <= merge(ctrl_reg, w_data_reg, w_strb_reg)
                                & WMASK; // RULE17 RULE3
                end
                if (wr_ofs == timer_set_pkg::OFS_PERIOD) begin
                    period_reg <= merge(period_reg, w_data_reg, w_strb_reg);
                end
            end
        end

        // Count register
        always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
                count_reg <= timer_set_pkg::COUNT_RST;
            end else if (wr_hit && wr_ofs == timer_set_pkg::OFS_COUNT) begin
                count_reg <= merge(count_reg, w_data_reg, w_strb_reg);
            end else if (tick) begin
                if (match) begin
                    count_reg <= timer_set_pkg::COUNT_RST; // RULE18 RULE15
                end else if (carry) begin
                    count_reg <= count_reg + 16'h0001; // RULE18 RULE19
                end
            end
        end
    end

    // Sticky status, write one to clear, events win
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= '0;
            mask_reg <= '0;
        end else begin
            if (wr_en && aw_addr_reg[7:0] ==
                timer_set_pkg::STATUS_ADDR && wr_ok) begin
                status_reg <= (status_reg & ~w_data_reg[N-1:0]) | event_w;
            end else begin
                status_reg <= status_reg | event_w;
            end
            if (wr_en && aw_addr_reg[7:0] ==
                timer_set_pkg::MASK_ADDR && wr_ok) begin
                mask_reg <= w_data_reg[N-1:0];
            end
        end
    end

    // Interrupt and converter trigger outputs
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_reg <= 1'b0;
            trig_reg <= 1'b0;
        end else begin
            irq_reg <= |(status_reg & mask_reg);
            trig_reg <= event_w[timer_set_pkg::TRIG_CH]; // RULE16
        end
    end

    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign irq = irq_reg;
    assign adc_trigger = trig_reg;

endmodule // timer_set

// >>> dv/timer_set_properties.sv
`timescale 1ns/100ps
module timer_set_properties #(
    parameter int ADDR_W = 8
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic irq,
    input wire logic adc_trigger
);
    logic [ADDR_W-1:0] aw_q;
    logic [ADDR_W-1:0] ar_q;
    logic [4:0] mask_q;
    logic wr_take;
    assign wr_take = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    // Last accepted addresses and mask
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            aw_q <= '0;
            ar_q <= '0;
            mask_q <= 5'h00;
        end else begin
            if (wr_take) aw_q <= s_axi_awaddr;
            if (s_axi_arvalid && s_axi_arready) ar_q <= s_axi_araddr;
            if (wr_take && s_axi_awaddr == timer_set_pkg::MASK_ADDR)
                mask_q <= s_axi_wdata[4:0];
        end
    end
    write_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response late");
    write_busy_a: assert property (wr_take |=> !s_axi_awready [*2])
        else $error("write slot reopened early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
        s_axi_rvalid && !s_axi_arready) else $error("read response late");
    read_refused_a: assert property (s_axi_rvalid && ar_q >= 8'h58 |->
        s_axi_rdata == 32'h0 && s_axi_rresp == timer_set_pkg::RESP_SLVERR)
        else $error("unmapped read not refused");
    write_refused_a: assert property (s_axi_bvalid && aw_q >= 8'h58 |->
        s_axi_bresp == timer_set_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    ctrl_zero_a: assert property (
        s_axi_rvalid && ar_q[3:0] == 4'h0 && ar_q < 8'h50 |->
        (s_axi_rdata & 32'hffff5f81) == 32'h0)
        else $error("unimplemented control bit reads one");
    irq_masked_a: assert property ((mask_q == 5'h00) [*4] |-> !irq)
        else $error("interrupt with all sources masked");
    irq_cause_a: assert property ($rose(irq) |-> mask_q != 5'h00)
        else $error("interrupt rose without enabled source");
    trig_pulse_a: assert property (adc_trigger |=> !adc_trigger)
        else $error("converter trigger wider than one cycle");
    irq_seen_c: cover property ($rose(irq));
    trig_seen_c: cover property (adc_trigger);
    refused_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // timer_set_properties

bind timer_set timer_set_properties #(.ADDR_W(ADDR_W)) u_props (
    .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .irq, .adc_trigger
);

// >>> dv/pin_source.sv
`timescale 1ns/100ps
module pin_source (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic [4:0] clk_en,
    input wire logic [4:0] gate_lvl,
    output logic [4:0] ext_clock_pin,
    output logic [4:0] gate_pin,
    output int rises
);
    logic [1:0] phase_reg;
    // Pin clock toggles every third cycle while enabled, else rests low
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            phase_reg <= 2'h0;
            ext_clock_pin <= 5'h00;
            rises <= 0;
        end else begin
            phase_reg <= (phase_reg == 2'h2) ? 2'h0 : phase_reg + 2'h1;
            if (phase_reg == 2'h2) begin
                ext_clock_pin <= ~ext_clock_pin & clk_en;
                if ((~ext_clock_pin & clk_en) != 5'h00) rises <= rises + 1;
            end
        end
    end
    // Gate level follows the bench request
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) gate_pin <= 5'h00;
        else gate_pin <= gate_lvl;
    end
endmodule // pin_source

// >>> dv/general_purpose_timer_set_test.sv
`timescale 1ns/100ps
module general_purpose_timer_set_test;
    localparam int ST = 5;
    logic sys_clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic idle_mode = 1'b0;
    logic [4:0] clk_en = 5'h00;
    logic [4:0] gate_lvl = 5'h00;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, irq, adc_trigger;
    logic [1:0] s_axi_bresp, s_axi_rresp, br, rr;
    logic [31:0] s_axi_rdata, rv;
    logic [4:0] ext_clock_pin, gate_pin;
    int rises;
    int adc_seen = 0;
    int err_count = 0;
    int checked = 0;
    int seed = 32'h4863;
    int div_q[$] = '{1, 8, 64, 256};

    timer_set #(.ADDR_W(8)) u_dut (
        .sys_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'h3), .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1), .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready(1'b1), .ext_clock_pin, .gate_pin,
        .idle_mode, .irq, .adc_trigger
    );
    pin_source u_pins (
        .sys_clk, .nrst, .clk_en, .gate_lvl, .ext_clock_pin, .gate_pin,
        .rises
    );

    initial forever #25 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (adc_trigger === 1'b1) adc_seen++;

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hang;
        err_count++;
        tally_and_finish();
    endtask
    task automatic wr(input int ch, input logic [3:0] o, input logic [15:0] d);
        int n;
        s_axi_awaddr <= {ch[3:0], o};
        s_axi_wdata <= {16'h0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
            if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid === 1'b1) break;
        end
        br = s_axi_bresp;
        if (n == 50) hang();
    endtask
    task automatic rd(input int ch, input logic [3:0] o);
        int n;
        s_axi_araddr <= {ch[3:0], o};
        s_axi_arvalid <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge sys_clk);
            if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid === 1'b1) break;
        end
        rv = s_axi_rdata;
        rr = s_axi_rresp;
        if (n == 50) hang();
    endtask
    task automatic rdc(input int ch, input logic [3:0] o,
        input logic [31:0] exp);
        rd(ch, o);
        chk(rv, exp);
    endtask
    task automatic wait_irq;
        int n;
        for (n = 0; n < 5000; n++) begin
            @(posedge sys_clk);
            if (irq === 1'b1) break;
        end
        if (n == 5000) hang();
    endtask
    function automatic logic [15:0] cmask(input int ch);
        if (ch == 0) return timer_set_pkg::CTRL_MASK_SA;
        return ch[0] ? timer_set_pkg::CTRL_MASK_LO
            : timer_set_pkg::CTRL_MASK_UP;
    endfunction

    initial begin
        int ch;
        int c;
        int p;
        repeat (8) @(posedge sys_clk);
        nrst <= 1'b1;
        @(posedge sys_clk);
        for (ch = 0; ch < 5; ch++) begin
            rdc(ch, 4'h0, 32'h0);
            rdc(ch, 4'h4, 32'h0000ffff);
            rdc(ch, 4'h8, 32'h0);
            wr(ch, 4'h0, 16'h5fff);
            rdc(ch, 4'h0, {16'h0, 16'h5fff & cmask(ch)});
            wr(ch, 4'h0, 16'h0000);
        end
        rdc(ST, 4'h8, 32'h0);
        chk({30'h0, rr}, {30'h0, timer_set_pkg::RESP_SLVERR});
        wr(ST, 4'hc, 16'h1234);
        chk({30'h0, br}, {30'h0, timer_set_pkg::RESP_SLVERR});
        for (c = 0; c < 4; c++) begin
            wr(1, 4'h8, 16'h0000);
            wr(1, 4'h0, 16'h8000 | 16'(c << 4));
            repeat (6 * div_q[c] - 3) @(posedge sys_clk);
            wr(1, 4'h0, 16'h0000);
            rd(1, 4'h8);
            chk(32'(rv >= 2 && rv <= 4), 32'h1);
        end
        p = 2 + ($random(seed) & 3);
        wr(ST, 4'h4, 16'h0001);
        wr(0, 4'h4, 16'(p));
        wr(0, 4'h0, 16'h8000);
        wait_irq();
        wr(0, 4'h0, 16'h0000);
        rd(0, 4'h8);
        chk(32'(rv <= p), 32'h1);
        rdc(ST, 4'h0, 32'h1);
        wr(ST, 4'h0, 16'h0001);
        repeat (2) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h0);
        chk(32'(adc_seen), 32'h0);
        idle_mode <= 1'b1;
        wr(0, 4'h4, 16'hffff);
        wr(0, 4'h8, 16'h0000);
        wr(0, 4'h0, 16'ha000);
        repeat (20) @(posedge sys_clk);
        rdc(0, 4'h8, 32'h0);
        wr(0, 4'h0, 16'h8000);
        repeat (20) @(posedge sys_clk);
        rd(0, 4'h8);
        chk(32'(rv != 0), 32'h1);
        idle_mode <= 1'b0;
        wr(ST, 4'h4, 16'h0000);
        wr(0, 4'h0, 16'h0000);
        wr(0, 4'h8, 16'h0000);
        wr(0, 4'h0, 16'h8040);
        repeat (20) @(posedge sys_clk);
        rdc(0, 4'h8, 32'h0);
        gate_lvl <= 5'h01;
        repeat (20) @(posedge sys_clk);
        gate_lvl <= 5'h00;
        repeat (8) @(posedge sys_clk);
        wr(0, 4'h0, 16'h0000);
        rd(0, 4'h8);
        chk(32'(rv > 5), 32'h1);
        rdc(ST, 4'h0, 32'h1);
        chk({31'h0, irq}, 32'h0);
        wr(ST, 4'h4, 16'h0001);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, irq}, 32'h1);
        wr(ST, 4'h0, 16'h001f);
        for (c = 0; c < 3; c++) begin
            ch = (c == 2) ? 1 : 0;
            wr(ch, 4'h8, 16'h0000);
            wr(ch, 4'h0, (c == 1) ? 16'h8006 : 16'h8002);
            p = rises;
            clk_en <= 5'(1 << ch);
            repeat (40 + ($random(seed) & 15)) @(posedge sys_clk);
            clk_en <= 5'h00;
            repeat (12) @(posedge sys_clk);
            rdc(ch, 4'h8, 32'(rises - p));
            wr(ch, 4'h0, 16'h0000);
        end
        wr(ST, 4'h4, 16'h001f);
        for (c = 1; c < 4; c += 2) begin
            wr(ST, 4'h0, 16'h001f);
            wr(c, 4'h8, 16'hfffe);
            wr(c + 1, 4'h8, 16'h0000);
            wr(c, 4'h4, 16'h0002);
            wr(c + 1, 4'h4, 16'h0001);
            wr(c + 1, 4'h0, 16'h8030);
            wr(c, 4'h0, 16'h8008);
            repeat (3) @(posedge sys_clk);
            wr(c, 4'h0, 16'h0008);
            rdc(c + 1, 4'h8, 32'h1);
            wr(c, 4'h0, 16'h8008);
            wait_irq();
            rdc(ST, 4'h0, 32'(1 << (c + 1)));
            chk(32'(adc_seen), 32'(c == 3));
        end
        tally_and_finish();
    end
endmodule // general_purpose_timer_set_test
